// >>> logic/lcl_regs.sv
`timescale 1ns/1ps
`include "lcl_params.svh"
module lcl_regs #(
    parameter int HOOK_STEP_CYCLES = `LCL_HOOK_STEP_PS / `LCL_CLK_PERIOD_PS,
    parameter longint PIN_BASE_CYCLES = longint'(`LCL_PIN_BASE_PS) / `LCL_CLK_PERIOD_PS,
    parameter longint PIN_STEP_CYCLES = longint'(`LCL_PIN_STEP_PS) / `LCL_CLK_PERIOD_PS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic host_byte_valid,
    input wire logic [7:0] host_byte,
    input wire logic [3:0] chan_enable,
    input wire logic host_port_mode,
    input wire logic companded_format,
    output logic host_rd_valid,
    output logic [7:0] host_rd_data,
    input wire logic [3:0][15:0] meter_sample,
    output logic [3:0][15:0] meter_level,
    output logic [3:0][3:0] meter_source_sel,
    output logic [3:0] meter_extra_gain,
    output logic [3:0] meter_rectifier_en,
    output logic [3:0] over_threshold_flag,
    output logic [3:0] hook_sample_tick,
    output logic [3:0][23:0] pin_debounce_cycles,
    input wire logic [3:0] tx_sample_valid,
    input wire logic [3:0][15:0] tx_sample,
    output logic [3:0][7:0] recog_time_field,
    output logic [3:0][7:0] recog_break_field,
    output logic [3:0][7:0] end_time_field,
    output logic [3:0][7:0] end_break_field,
    input wire logic [3:0][3:0] gndkey_status,
    input wire logic [3:0][3:0] offhook_status,
    input wire logic [3:0] overtemp_status,
    input wire logic [3:0] ramp_done_status,
    input wire logic [3:0] gndkey_polarity_status,
    input wire logic [3:0] src_reg_read,
    output logic [3:0] hook_gk_event,
    output logic [3:0] line_event_pending
);
    lcl_pkg::lcl_cmd_state_type state_ff;
    logic [4:0] ofs_ff;
    logic [3:0] wr_chan_ff;
    logic wr_strobe;
    logic rd_strobe;
    logic [3:0][7:0] rd_word;
    logic [7:0] nxt_rd_data;
    logic [4:0] cmd_ofs;

    assign cmd_ofs = host_byte[`LCL_CMD_OFS_MSB:0];
    assign wr_strobe = host_byte_valid && state_ff == lcl_pkg::LCL_CMD_DATA;
    assign rd_strobe = host_byte_valid && state_ff == lcl_pkg::LCL_CMD_IDLE
        && !host_byte[`LCL_CMD_WRITE_BIT];

    // write command waits for one data byte, read answers at once
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= lcl_pkg::LCL_CMD_IDLE;
            ofs_ff <= 5'h00;
            wr_chan_ff <= 4'h0;
        end else begin
            case (state_ff)
                lcl_pkg::LCL_CMD_IDLE: begin
                    if (host_byte_valid) begin
                        ofs_ff <= cmd_ofs;
                        wr_chan_ff <= chan_enable;
                        if (host_byte[`LCL_CMD_WRITE_BIT]) begin
                            state_ff <= lcl_pkg::LCL_CMD_DATA;
                        end
                    end
                end
                lcl_pkg::LCL_CMD_DATA: begin
                    if (host_byte_valid) begin
                        state_ff <= lcl_pkg::LCL_CMD_IDLE;
                    end
                end
                default: begin
                    state_ff <= lcl_pkg::LCL_CMD_IDLE;
                end
            endcase
        end
    end

    // lowest enabled channel answers a read; none enabled reads zero
    always_comb begin
        nxt_rd_data = `LCL_ZERO_BYTE;
        for (int c = `LCL_CHANNELS - 1; c >= 0; c--) begin
            if (chan_enable[c]) begin
                nxt_rd_data = rd_word[c];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            host_rd_valid <= 1'b0;
            host_rd_data <= `LCL_ZERO_BYTE;
        end else begin
            host_rd_valid <= rd_strobe;
            // data holds until the next read
            if (rd_strobe) begin
                host_rd_data <= nxt_rd_data;
            end
        end
    end

    for (genvar ch = 0; ch < `LCL_CHANNELS; ch++) begin : g_chan
        logic [7:0] meter_ff;
        logic [7:0] debounce_ff;
        logic [7:0] tx_low_ff;
        logic [7:0] tx_high_ff;
        logic [7:0] recog_time_ff;
        logic [7:0] recog_break_ff;
        logic [7:0] end_time_ff;
        logic [7:0] end_break_ff;
        logic [7:0] mask_ff;
        logic [15:0] level_ff;
        logic flag_ff;
        logic [18:0] hook_cnt_ff;
        logic [23:0] pin_cyc_ff;
        logic tick_ff;
        logic [3:0] gk_last_ff;
        logic [3:0] hk_last_ff;
        logic ot_last_ff;
        logic ramp_last_ff;
        logic pol_last_ff;
        logic pend_ff;
        logic hk_evt_ff;
        logic wr_here;
        logic [15:0] nxt_level;
        logic [15:0] magnitude;
        logic [15:0] threshold;
        logic [19:0] gained;
        logic [18:0] hook_limit;
        logic rise_evt;
        logic [3:0] meter_src_ff;

        assign wr_here = wr_strobe && wr_chan_ff[ch];

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                meter_ff <= `LCL_RST_METER;
                debounce_ff <= `LCL_RST_DEBOUNCE;
                recog_time_ff <= `LCL_RST_RECOG_TIME;
                recog_break_ff <= `LCL_RST_RECOG_BREAK;
                end_time_ff <= `LCL_RST_END_TIME;
                end_break_ff <= `LCL_RST_END_BREAK;
                mask_ff <= `LCL_RST_MASK;
            end else if (wr_here) begin
                case (ofs_ff)
                    // flag and reserved bits never take a write
                    `LCL_OFS_METER: meter_ff <= host_byte & `LCL_METER_WR_MASK;
                    `LCL_OFS_DEBOUNCE: debounce_ff <= host_byte;
                    `LCL_OFS_RECOG_TIME: recog_time_ff <= host_byte;
                    `LCL_OFS_RECOG_BREAK: recog_break_ff <= host_byte;
                    `LCL_OFS_END_TIME: end_time_ff <= host_byte;
                    `LCL_OFS_END_BREAK: end_break_ff <= host_byte;
                    `LCL_OFS_MASK: mask_ff <= host_byte & `LCL_MASK_WR_MASK;
                    default: begin
                    end
                endcase
            end
        end

        // gain, then optional rectifier; saturate so x16 cannot wrap
        always_comb begin
            gained = {{4{meter_sample[ch][15]}}, meter_sample[ch]} <<< `LCL_GAIN_SHIFT;
            nxt_level = meter_sample[ch];
            if (meter_ff[`LCL_GAIN_BIT]) begin
                if (gained[19:15] != {5{gained[19]}}) begin
                    nxt_level = gained[19] ? `LCL_SAT_NEG : `LCL_SAT_POS;
                end else begin
                    nxt_level = gained[15:0];
                end
            end
            if (meter_ff[`LCL_RECT_BIT] && nxt_level[15]) begin
                nxt_level = 16'(-nxt_level);
            end
            magnitude = level_ff[15] ? 16'(-level_ff) : level_ff;
            // full scale 32768, one code step is an eighth of it
            threshold = 16'(meter_ff[`LCL_TH_MSB:0]) << `LCL_TH_SHIFT;
        end

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                level_ff <= 16'h0000;
                flag_ff <= 1'b0;
            end else begin
                level_ff <= nxt_level;
                flag_ff <= magnitude > threshold;
            end
        end

        // hook sampling strobe every (code+1) steps
        // 19 bits hold sixteen steps at the full step count
        assign hook_limit = 19'((debounce_ff[7:4] + 19'h1)
            * HOOK_STEP_CYCLES - 1);
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                hook_cnt_ff <= 19'h00000;
                tick_ff <= 1'b0;
            end else if (hook_cnt_ff >= hook_limit) begin
                hook_cnt_ff <= 19'h00000;
                tick_ff <= 1'b1;
            end else begin
                hook_cnt_ff <= hook_cnt_ff + 19'h1;
                tick_ff <= 1'b0;
            end
        end

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                pin_cyc_ff <= 24'(PIN_BASE_CYCLES);
            end else begin
                pin_cyc_ff <= 24'(PIN_BASE_CYCLES
                    + debounce_ff[3:0] * PIN_STEP_CYCLES);
            end
        end

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                tx_low_ff <= `LCL_ZERO_BYTE;
                tx_high_ff <= `LCL_ZERO_BYTE;
            end else if (tx_sample_valid[ch]) begin
                tx_low_ff <= tx_sample[ch][7:0];
                tx_high_ff <= companded_format ? `LCL_ZERO_BYTE
                    : tx_sample[ch][15:8];
            end
        end

        // edge events; pending stays until a source read, set beats clear
        assign rise_evt = (!mask_ff[`LCL_OVERTEMP_MASK_BIT]
            && overtemp_status[ch] && !ot_last_ff)
            || (!mask_ff[`LCL_RAMP_M_BIT] && ramp_done_status[ch] && !ramp_last_ff)
            || (!mask_ff[`LCL_GNDKEY_POLARITY_MASK_BIT]
                && (gndkey_polarity_status[ch] != pol_last_ff));
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                gk_last_ff <= 4'h0;
                hk_last_ff <= 4'h0;
                ot_last_ff <= 1'b0;
                ramp_last_ff <= 1'b0;
                // history starts at the idle level, so release shows no edge
                pol_last_ff <= 1'b1;
                pend_ff <= 1'b0;
                hk_evt_ff <= 1'b0;
            end else begin
                gk_last_ff <= gndkey_status[ch];
                hk_last_ff <= offhook_status[ch];
                ot_last_ff <= overtemp_status[ch];
                ramp_last_ff <= ramp_done_status[ch];
                pol_last_ff <= gndkey_polarity_status[ch];
                hk_evt_ff <= (!mask_ff[`LCL_GK_M_BIT]
                    && gndkey_status[ch] != gk_last_ff)
                    || (!mask_ff[`LCL_HK_M_BIT] && offhook_status[ch] != hk_last_ff);
                if (rise_evt) begin
                    pend_ff <= 1'b1;
                end else if (src_reg_read[ch]) begin
                    pend_ff <= 1'b0;
                end
            end
        end

        // keyed on the live command byte; the stored offset is a cycle late
        always_comb begin
            case (cmd_ofs)
                `LCL_OFS_SOURCE: rd_word[ch] = {4'h0, meter_src_ff};
                `LCL_OFS_METER: rd_word[ch] = {flag_ff, meter_ff[6:0]};
                `LCL_OFS_DEBOUNCE: rd_word[ch] = debounce_ff;
                `LCL_OFS_TX_LOW:
                    rd_word[ch] = host_port_mode ? tx_low_ff : `LCL_ZERO_BYTE;
                `LCL_OFS_TX_HIGH:
                    rd_word[ch] = host_port_mode ? tx_high_ff : `LCL_ZERO_BYTE;
                `LCL_OFS_RECOG_TIME: rd_word[ch] = recog_time_ff;
                `LCL_OFS_RECOG_BREAK: rd_word[ch] = recog_break_ff;
                `LCL_OFS_END_TIME: rd_word[ch] = end_time_ff;
                `LCL_OFS_END_BREAK: rd_word[ch] = end_break_ff;
                `LCL_OFS_MASK: rd_word[ch] = mask_ff;
                default: rd_word[ch] = `LCL_ZERO_BYTE;
            endcase
        end

        assign meter_level[ch] = level_ff;
        assign meter_source_sel[ch] = meter_src_ff;
        assign meter_extra_gain[ch] = meter_ff[`LCL_GAIN_BIT];
        assign meter_rectifier_en[ch] = meter_ff[`LCL_RECT_BIT];
        assign over_threshold_flag[ch] = flag_ff;
        assign hook_sample_tick[ch] = tick_ff;
        assign pin_debounce_cycles[ch] = pin_cyc_ff;
        assign recog_time_field[ch] = recog_time_ff;
        assign recog_break_field[ch] = recog_break_ff;
        assign end_time_field[ch] = end_time_ff;
        assign end_break_field[ch] = end_break_ff;
        assign hook_gk_event[ch] = hk_evt_ff;
        assign line_event_pending[ch] = pend_ff;

        // source select lives in the register just below this bank
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                meter_src_ff <= `LCL_RST_SOURCE;
            end else if (wr_here && ofs_ff == `LCL_OFS_SOURCE) begin
                meter_src_ff <= host_byte[3:0];
            end
        end
    end
endmodule

// >>> pkg/lcl_params.svh
`ifndef LCL_PARAMS_SVH
`define LCL_PARAMS_SVH
// Operation
// - meter source select field routes meter input
// - read-only flag set when magnitude exceeds threshold
// - threshold is code times 12.5 percent
// - gain bit multiplies meter signal by 16
// - rectifier in path only while enabled
// - hook interval (code+1) times 0.125 ms
// - pin debounce 2.5 ms plus 2 ms per step
// - low monitor holds low byte or compressed code
// - high monitor holds upper byte, else zero
// - monitors read-only, only in serial-port mode
// - recognition time field, 16 ms units, reset 13h
// - recognition break field, 4 ms units, reset 19h
// - end time field, 4 ms units, reset 40h
// - end break field in ms, reset 64h
// - ground-key changes interrupt unless masked
// - off-hook changes interrupt unless masked
// - over-temperature rising edge interrupts unless masked
// - ramp-complete rising edge interrupts unless masked
// - polarity change either way interrupts unless masked
// - command byte: low five bits offset, bit7 write
// - source register read clears ramp, temp, polarity
`define LCL_CHANNELS 4
`define LCL_OFS_SOURCE 5'h08
`define LCL_RST_SOURCE 4'h0
`define LCL_SAT_POS 16'h7fff
`define LCL_SAT_NEG 16'h8000
`define LCL_OFS_METER 5'h09
`define LCL_OFS_DEBOUNCE 5'h0a
`define LCL_OFS_TX_LOW 5'h0b
`define LCL_OFS_TX_HIGH 5'h0c
`define LCL_OFS_RECOG_TIME 5'h0d
`define LCL_OFS_RECOG_BREAK 5'h0e
`define LCL_OFS_END_TIME 5'h0f
`define LCL_OFS_END_BREAK 5'h10
`define LCL_OFS_MASK 5'h11
`define LCL_CMD_WRITE_BIT 7
`define LCL_CMD_OFS_MSB 4
`define LCL_RST_METER 8'h00
`define LCL_RST_DEBOUNCE 8'h00
`define LCL_RST_RECOG_TIME 8'h13
`define LCL_RST_RECOG_BREAK 8'h19
`define LCL_RST_END_TIME 8'h40
`define LCL_RST_END_BREAK 8'h64
`define LCL_RST_MASK 8'h1f
`define LCL_METER_WR_MASK 8'h67
`define LCL_MASK_WR_MASK 8'h1f
`define LCL_FLAG_BIT 7
`define LCL_GAIN_BIT 6
`define LCL_RECT_BIT 5
`define LCL_TH_MSB 2
`define LCL_GK_M_BIT 4
`define LCL_HK_M_BIT 3
`define LCL_OVERTEMP_MASK_BIT 2
`define LCL_RAMP_M_BIT 1
`define LCL_GNDKEY_POLARITY_MASK_BIT 0
`define LCL_GAIN_SHIFT 4
`define LCL_TH_SHIFT 12
`define LCL_CLK_PERIOD_PS 4000
`define LCL_HOOK_STEP_PS 125000000
`define LCL_PIN_BASE_PS 2500000000
`define LCL_PIN_STEP_PS 2000000000
`define LCL_ZERO_BYTE 8'h00
`endif

// >>> pkg/lcl_pkg.sv
package lcl_pkg;
    typedef enum logic [1:0] {
        LCL_CMD_IDLE = 2'b01,
        LCL_CMD_DATA = 2'b10
    } lcl_cmd_state_type;
endpackage

// >>> sim/lcl_host_model.sv
`timescale 1ns/1ps
module lcl_host_model (
    input wire logic sys_clk,
    input wire logic host_rd_valid,
    input wire logic [7:0] host_rd_data,
    output logic host_byte_valid,
    output logic [7:0] host_byte,
    output logic [3:0] chan_enable
);
    initial begin
        host_byte_valid = 1'b0;
        host_byte = 8'h00;
        chan_enable = 4'h0;
    end
    // command then one data byte, no auto-increment
    task automatic wr(input logic [3:0] m, input logic [4:0] o, input logic [7:0] d);
        @(posedge sys_clk);
        chan_enable <= m;
        host_byte_valid <= 1'b1;
        host_byte <= {3'b100, o};
        @(posedge sys_clk);
        host_byte <= d;
        @(posedge sys_clk);
        host_byte_valid <= 1'b0;
        host_byte <= ~d;
    endtask
    // idle byte inverted so a stale value never passes
    task automatic rd(input logic [3:0] m, input logic [4:0] o, output logic [7:0] d);
        @(posedge sys_clk);
        chan_enable <= m;
        host_byte_valid <= 1'b1;
        host_byte <= {3'b000, o};
        @(posedge sys_clk);
        host_byte_valid <= 1'b0;
        host_byte <= {3'b111, ~o};
        #1;
        repeat (4) if (host_rd_valid !== 1'b1) @(posedge sys_clk) #1;
        d = host_rd_valid === 1'b1 ? host_rd_data : 8'hxx;
    endtask
endmodule

// >>> sim/lcl_regs_assertions.sv
`timescale 1ns/1ps
module lcl_chk #(
    parameter int HOOK_STEP_CYCLES = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic host_byte_valid,
    input wire logic [7:0] host_byte,
    input wire logic host_port_mode,
    input wire logic host_rd_valid,
    input wire logic [7:0] host_rd_data,
    input wire logic [3:0] hook_sample_tick,
    input wire logic [3:0][7:0] recog_time_field,
    input wire logic [3:0][3:0] gndkey_status,
    input wire logic [3:0][3:0] offhook_status,
    input wire logic [3:0] overtemp_status,
    input wire logic [3:0] ramp_done_status,
    input wire logic [3:0] gndkey_polarity_status,
    input wire logic [3:0] hook_gk_event,
    input wire logic [3:0] line_event_pending
);
    localparam int TICK_MAX = 16 * HOOK_STEP_CYCLES;
    logic data_ff;
    logic rd_cmd;
    logic [19:0] since_tick_ff;
    assign rd_cmd = host_byte_valid && !data_ff && !host_byte[7];
    // next valid byte is write data, not a command
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_ff <= 1'b0;
        end else if (host_byte_valid) begin
            data_ff <= !data_ff && host_byte[7];
        end
    end
    // longest period is sixteen steps, too long for a delay range
    always_ff @(posedge sys_clk) begin
        if (rst || hook_sample_tick[0]) begin
            since_tick_ff <= 20'h00000;
        end else begin
            since_tick_ff <= since_tick_ff + 20'h00001;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_read_answer: assert property (rd_cmd |=> host_rd_valid)
        else $error("read not answered");
    a_answer_cause: assert property (host_rd_valid |-> $past(rd_cmd))
        else $error("answer without read");
    a_monitor_hidden: assert property (
        rd_cmd && !host_port_mode && (host_byte[4:0] == 5'h0b || host_byte[4:0] == 5'h0c)
        |=> host_rd_data == 8'h00) else $error("monitor visible");
    a_field_by_write: assert property (
        $changed(recog_time_field[0]) |-> $past(host_byte_valid && data_ff))
        else $error("field changed alone");
    a_tick_gap_min: assert property (
        hook_sample_tick[0] |=> !hook_sample_tick[0] [*3]) else $error("ticks too close");
    a_tick_gap_max: assert property (
        since_tick_ff < 20'(TICK_MAX)) else $error("tick missing");
    a_event_cause: assert property (
        hook_gk_event[0] |-> $past(gndkey_status[0]) != $past(gndkey_status[0], 2)
        || $past(offhook_status[0]) != $past(offhook_status[0], 2))
        else $error("event without change");
    a_pending_cause: assert property (
        $rose(line_event_pending[0]) |->
        $past(overtemp_status[0]) && !$past(overtemp_status[0], 2)
        || $past(ramp_done_status[0]) && !$past(ramp_done_status[0], 2)
        || $past(gndkey_polarity_status[0]) != $past(gndkey_polarity_status[0], 2))
        else $error("pending without cause");
endmodule
bind lcl_regs lcl_chk #(.HOOK_STEP_CYCLES(HOOK_STEP_CYCLES)) i_chk (.sys_clk(sys_clk),
    .rst(rst), .host_byte_valid(host_byte_valid), .host_byte(host_byte),
    .host_port_mode(host_port_mode), .host_rd_valid(host_rd_valid),
    .host_rd_data(host_rd_data), .hook_sample_tick(hook_sample_tick),
    .recog_time_field(recog_time_field), .gndkey_status(gndkey_status),
    .offhook_status(offhook_status), .overtemp_status(overtemp_status),
    .ramp_done_status(ramp_done_status), .gndkey_polarity_status(gndkey_polarity_status),
    .hook_gk_event(hook_gk_event), .line_event_pending(line_event_pending));

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module tb_top;
    logic sys_clk = 1'b0, rst = 1'b1, port_mode = 1'b1, compand = 1'b0, bv, rv;
    logic [3:0][15:0] msample = '0, tx = '0, mlevel;
    logic [3:0][3:0] gk = '0, hk = '0, msel;
    logic [3:0] txv = '0, ot = '0, ramp = '0, pol = 4'hf, srd = '0;
    logic [3:0] gain, rect, flag, tick, hev, pend, cen;
    logic [3:0][23:0] pin;
    logic [3:0][7:0] rtf, rbf, etf, ebf;
    logic [7:0] hb, rdat;
    logic [7:0] rg [4][32];
    logic [7:0] mon [4][2];
    int cmp_count = 0, fail_count = 0;
    always #2 sys_clk = ~sys_clk;
    lcl_host_model i_host (.sys_clk(sys_clk), .host_rd_valid(rv), .host_rd_data(rdat),
        .host_byte_valid(bv), .host_byte(hb), .chan_enable(cen));
    lcl_regs #(.HOOK_STEP_CYCLES(4), .PIN_BASE_CYCLES(5), .PIN_STEP_CYCLES(4)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .host_byte_valid(bv), .host_byte(hb),
        .chan_enable(cen), .host_port_mode(port_mode), .companded_format(compand),
        .host_rd_valid(rv), .host_rd_data(rdat), .meter_sample(msample), .meter_level(mlevel),
        .meter_source_sel(msel), .meter_extra_gain(gain), .meter_rectifier_en(rect),
        .over_threshold_flag(flag), .hook_sample_tick(tick), .pin_debounce_cycles(pin),
        .tx_sample_valid(txv), .tx_sample(tx), .recog_time_field(rtf),
        .recog_break_field(rbf), .end_time_field(etf), .end_break_field(ebf),
        .gndkey_status(gk), .offhook_status(hk), .overtemp_status(ot),
        .ramp_done_status(ramp), .gndkey_polarity_status(pol), .src_reg_read(srd),
        .hook_gk_event(hev), .line_event_pending(pend));
    function automatic logic [7:0] wm(input int o);
        return o == 8 ? 8'h0f : o == 9 ? 8'h67 : o == 17 ? 8'h1f
            : (o == 10 || (o > 12 && o < 17)) ? 8'hff : 8'h00;
    endfunction
    task automatic wr(input logic [3:0] m, input int o, input logic [7:0] d);
        i_host.wr(m, 5'(o), d);
        for (int c = 0; c < 4; c++) if (m[c]) rg[c][o] = (rg[c][o] & ~wm(o)) | (d & wm(o));
    endtask
    task automatic rd(input logic [3:0] m, input int o);
        logic [7:0] d;
        logic [7:0] e;
        int c;
        i_host.rd(m, 5'(o), d);
        c = m[0] ? 0 : m[1] ? 1 : m[2] ? 2 : 3;
        e = (o == 11 || o == 12) ? (port_mode ? mon[c][o - 11] : 8'h00) : rg[c][o];
        `CHK(d, e)
    endtask
    task automatic outs();
        for (int c = 0; c < 4; c++) begin
            `CHK({msel[c], gain[c], rect[c]}, {rg[c][8][3:0], rg[c][9][6:5]})
            `CHK(pin[c], 24'(5 + 4 * rg[c][10][3:0]))
            `CHK({rtf[c], rbf[c]}, {rg[c][13], rg[c][14]})
            `CHK({etf[c], ebf[c]}, {rg[c][15], rg[c][16]})
        end
    endtask
    task automatic gap(output int n);
        n = 0;
        do @(posedge sys_clk) #1 n++; while (tick[0] !== 1'b1 && n < 300);
    endtask
    task automatic step(input logic [10:0] s, input logic [3:0] eh, input logic ep, input logic clr);
        logic [3:0] n;
        n = 4'h0;
        @(posedge sys_clk);
        {gk[0], hk[0], ot[0], ramp[0], pol[0]} <= s;
        repeat (4) @(posedge sys_clk) #1 n += hev[0];
        `CHK(n, eh)
        `CHK(pend[0], ep)
        if (clr) begin
            @(posedge sys_clk);
            srd[0] <= 1'b1;
            @(posedge sys_clk);
            srd[0] <= 1'b0;
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        int n, s, lvl;
        logic [7:0] cfg;
        void'($urandom(32'hfae885bf));
        for (int c = 0; c < 4; c++) begin
            for (int o = 0; o < 32; o++) rg[c][o] = 8'h00;
            {rg[c][13], rg[c][14], rg[c][15], rg[c][16], rg[c][17]} = 40'h131940641f;
            mon[c] = '{8'h00, 8'h00};
        end
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        for (int o = 8; o < 20; o++) rd(4'h1, o);
        outs();
        for (int c = 0; c < 4; c++) begin
            for (int o = 8; o < 19; o++) wr(4'(1 << c), o, 8'($urandom));
        end
        wr(4'hf, 14, 8'h5a);
        for (int c = 0; c < 4; c++) begin
            for (int o = 8; o < 19; o++) rd(4'(1 << c), o);
        end
        rd(4'hc, 13);
        outs();
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            compand <= k[0];
            txv <= 4'hf;
            for (int c = 0; c < 4; c++) tx[c] <= 16'($urandom);
            @(posedge sys_clk);
            txv <= 4'h0;
            #1;
            for (int c = 0; c < 4; c++) mon[c] = '{tx[c][7:0], k ? 8'h00 : tx[c][15:8]};
            for (int c = 0; c < 4; c++) rd(4'(1 << c), 11);
            for (int c = 0; c < 4; c++) rd(4'(1 << c), 12);
        end
        @(posedge sys_clk);
        port_mode <= 1'b0;
        rd(4'h1, 11);
        rd(4'h1, 12);
        for (int k = 0; k < 3; k++) begin
            s = k == 0 ? 0 : k == 1 ? 7 : 15;
            wr(4'h1, 10, {4'(s), 4'h0});
            gap(n);
            gap(n);
            `CHK(n, (s + 1) * 4)
        end
        for (int k = 0; k < 8; k++) begin
            cfg = 8'($urandom) | (k == 7 ? 8'h40 : 8'h00);
            s = k == 7 ? 2100 : $urandom_range(4094) - 2047;
            wr(4'h1, 9, cfg);
            msample[0] <= 16'(s);
            repeat (3) @(posedge sys_clk);
            #1;
            lvl = cfg[6] ? s * 16 : s;
            lvl = lvl > 32767 ? 32767 : (cfg[5] && lvl < 0) ? -lvl : lvl;
            `CHK(mlevel[0], 16'(lvl))
            rg[0][9][7] = (lvl < 0 ? -lvl : lvl) > cfg[2:0] * 4096;
            `CHK(flag[0], rg[0][9][7])
            rd(4'h1, 9);
        end
        wr(4'h1, 17, 8'h00);
        step({4'h3, 4'h0, 3'b001}, 1, 0, 0);
        step({4'h3, 4'h1, 3'b001}, 1, 0, 0);
        step({4'h3, 4'h1, 3'b101}, 0, 1, 1);
        step({4'h3, 4'h1, 3'b001}, 0, 0, 0);
        step({4'h3, 4'h1, 3'b011}, 0, 1, 1);
        step({4'h3, 4'h1, 3'b010}, 0, 1, 1);
        wr(4'h1, 17, 8'h1f);
        step({4'h0, 4'h0, 3'b101}, 0, 0, 0);
        stop_test();
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        fail_count++;
        stop_test();
    end
endmodule
